// File: ov_protect_regs.vh
/*
 Register offsets, field positions and reset values for the overvoltage
 protection control block. Assumes a 32-bit classic Wishbone slave with
 one aligned word per register, byte addresses as given here.
*/
// Operation
// - Input threshold register keeps a writable 6-bit code, 0 to 63, in bits 5..0.
// - Threshold bits 7..6 read zero and ignore writes.
// - Enabled response plus overvoltage forces secondary drive high, primary drive low, unless input lockout holds both low.
// - Overvoltage flag sets on selected edge regardless of mask or global enable.
// - Control: enable bit 3 RW, status bit 2 RO, 7..4 zero, reset zero.
// - Status bit reads one while overvoltage present, zero otherwise.
// - Rise select bit 1 lets rising comparator edges set the flag.
// - Fall select bit 0 lets falling comparator edges set the flag.
// - Level register keeps a fully writable 8-bit DAC code, 0 to 255.
// - The level code feeds both comparator reference and regulation set point.
// - Input overvoltage with input enable set disables both gate drives.
`ifndef OV_PROTECT_REGS_VH
`define OV_PROTECT_REGS_VH
`define ADDR_IN_THRESH 5'h00
`define ADDR_OV_CTRL 5'h04
`define ADDR_OV_LEVEL 5'h08
`define ADDR_ANA_EN 5'h0c
`define ADDR_IRQ_STAT 5'h10
`define ADDR_IRQ_MASK 5'h14
`define ADDR_W 5
`define THRESH_W 6
`define CTRL_EN_BIT 3
`define CTRL_STAT_BIT 2
`define CTRL_RISE_BIT 1
`define CTRL_FALL_BIT 0
`define ANA_VAMP_DIS_BIT 0
`define ANA_IN_OV_EN_BIT 1
`define IRQ_OV_BIT 0
`define IRQ_IN_OV_BIT 1
`define IRQ_W 2
`define RST_THRESH 6'h00
`define RST_LEVEL 8'h00
`define RST_CTRL 4'h0
`define RST_ANA 2'h0
`define RST_MASK 2'h0
`define RST_STAT 1'b0
`endif

// File: edge_sync.v
/*
 Two-flop synchroniser with edge detector on the synchronised level.
 Assumes an asynchronous level input and one clock domain.
*/
`timescale 1ns/100ps
module edge_sync
(
   input wire core_clk_i,
   input wire reset_i,
   input wire async_i,
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta_q;
   reg sync_q;
   reg prev_q;
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign level_o = sync_q;
   assign rise_o = sync_q & ~prev_q;
   assign fall_o = ~sync_q & prev_q;
endmodule

// File: ov_protect_ctrl.v
/*
 Overvoltage protection control: threshold, control and level registers,
 sticky interrupt status with mask, gate drive forcing.
 Assumes classic Wishbone master on core_clk_i and analog comparators
 whose outputs are asynchronous levels.
*/
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "ov_protect_regs.vh"
module ov_protect_ctrl
(
   input wire core_clk_i,
   input wire reset_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire ov_comp_i,
   input wire in_ov_comp_i,
   input wire pwm_primary_i,
   input wire pwm_secondary_i,
   output reg primary_gate_drive_o,
   output reg secondary_gate_drive_o,
   output reg [5:0] input_ov_threshold_code_o,
   output reg [7:0] ov_level_code_o,
   output reg voltage_amp_disable_o,
   output reg irq_o
);
   // Software-visible registers
   reg [5:0] thresh_q;
   reg [7:0] level_q;
   reg [3:0] ctrl_q;
   reg [1:0] ana_q;
   reg [1:0] stat_q;
   reg [1:0] mask_q;

   // Combinational next values
   reg [31:0] rdata_d;
   reg prim_d;
   reg sec_d;

   // Synchronised comparator levels and edges
   wire ov_level;
   wire ov_rise;
   wire ov_fall;
   wire in_level;
   wire in_rise;
   wire in_fall;

   // Bus decode
   wire req;
   wire wr;
   wire [4:0] adr;
   wire wr_thresh;
   wire wr_ctrl;
   wire wr_level;
   wire wr_ana;
   wire wr_stat;
   wire wr_mask;

   // Protection and interrupt terms
   wire ov_force;
   wire in_lock;
   wire [1:0] stat_set;
   wire [1:0] stat_clr;
   wire [1:0] stat_d;
   wire irq_d;
   genvar g;

   edge_sync u_ov_sync
   (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i(ov_comp_i),
      .level_o(ov_level),
      .rise_o(ov_rise),
      .fall_o(ov_fall)
   );

   edge_sync u_in_sync
   (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i(in_ov_comp_i),
      .level_o(in_level),
      .rise_o(in_rise),
      .fall_o(in_fall)
   );

   // One access at a time; the ack cycle blocks a second take
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign adr = wb_adr_i[4:0];
   assign wr_thresh = wr & (adr == `ADDR_IN_THRESH);
   assign wr_ctrl = wr & (adr == `ADDR_OV_CTRL);
   assign wr_level = wr & (adr == `ADDR_OV_LEVEL);
   assign wr_ana = wr & (adr == `ADDR_ANA_EN);
   assign wr_stat = wr & (adr == `ADDR_IRQ_STAT);
   assign wr_mask = wr & (adr == `ADDR_IRQ_MASK);

   // Protection terms
   assign ov_force = ctrl_q[`CTRL_EN_BIT] & ov_level;
   assign in_lock = ana_q[`ANA_IN_OV_EN_BIT] & in_level;

   // Event sources per status bit; the mask plays no part here
   assign stat_set[`IRQ_OV_BIT] = (ov_rise & ctrl_q[`CTRL_RISE_BIT]) |
      (ov_fall & ctrl_q[`CTRL_FALL_BIT]);
   assign stat_set[`IRQ_IN_OV_BIT] = in_rise | in_fall;
   assign stat_clr = wr_stat ? wb_dat_i[`IRQ_W-1:0] : 2'h0;

   // Sticky status bits; hardware set wins over software clear
   generate
      for (g = 0; g < `IRQ_W; g = g + 1)
      begin : g_stat
         assign stat_d[g] = stat_set[g] | (stat_q[g] & ~stat_clr[g]);

         always @(posedge core_clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               stat_q[g] <= `RST_STAT;
            end
            else
            begin
               stat_q[g] <= stat_d[g];
            end
         end
      end
   endgenerate

   // Read data; unmapped and unimplemented bits read zero
   always @*
   begin
      rdata_d = 32'h00000000;
      case (adr)
         `ADDR_IN_THRESH:
         begin
            rdata_d[5:0] = thresh_q;
         end
         `ADDR_OV_CTRL:
         begin
            rdata_d[`CTRL_EN_BIT] = ctrl_q[`CTRL_EN_BIT];
            rdata_d[`CTRL_STAT_BIT] = ov_level;
            rdata_d[`CTRL_RISE_BIT] = ctrl_q[`CTRL_RISE_BIT];
            rdata_d[`CTRL_FALL_BIT] = ctrl_q[`CTRL_FALL_BIT];
         end
         `ADDR_OV_LEVEL:
         begin
            rdata_d[7:0] = level_q;
         end
         `ADDR_ANA_EN:
         begin
            rdata_d[1:0] = ana_q;
         end
         `ADDR_IRQ_STAT:
         begin
            rdata_d[1:0] = stat_q;
         end
         `ADDR_IRQ_MASK:
         begin
            rdata_d[1:0] = mask_q;
         end
         default:
         begin
            rdata_d = 32'h00000000;
         end
      endcase
   end

   // Registered answer, one cycle after the take
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req;
         if (req)
         begin
            wb_dat_o <= rdata_d;
         end
         else
         begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // Threshold code; upper bits are not stored
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         thresh_q <= `RST_THRESH;
      end
      else if (wr_thresh)
      begin
         thresh_q <= wb_dat_i[`THRESH_W-1:0];
      end
   end

   // Control; the status position is never stored, it reads the live level
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl_q <= `RST_CTRL;
      end
      else if (wr_ctrl)
      begin
         ctrl_q[`CTRL_EN_BIT] <= wb_dat_i[`CTRL_EN_BIT];
         ctrl_q[`CTRL_STAT_BIT] <= 1'b0;
         ctrl_q[`CTRL_RISE_BIT] <= wb_dat_i[`CTRL_RISE_BIT];
         ctrl_q[`CTRL_FALL_BIT] <= wb_dat_i[`CTRL_FALL_BIT];
      end
   end

   // Shared DAC level code
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         level_q <= `RST_LEVEL;
      end
      else if (wr_level)
      begin
         level_q <= wb_dat_i[7:0];
      end
   end

   // Analog enables: amp disable and input lockout enable
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ana_q <= `RST_ANA;
      end
      else if (wr_ana)
      begin
         ana_q <= wb_dat_i[1:0];
      end
   end

   // Interrupt mask, same layout as status
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mask_q <= `RST_MASK;
      end
      else if (wr_mask)
      begin
         mask_q <= wb_dat_i[`IRQ_W-1:0];
      end
   end

   // Analog-side copies, each straight from a flop
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         input_ov_threshold_code_o <= `RST_THRESH;
         ov_level_code_o <= `RST_LEVEL;
         voltage_amp_disable_o <= 1'b0;
      end
      else
      begin
         input_ov_threshold_code_o <= thresh_q;
         // One code serves comparator reference and regulation set point
         ov_level_code_o <= level_q;
         // Software must set this before relying on overvoltage response
         voltage_amp_disable_o <= ana_q[`ANA_VAMP_DIS_BIT];
      end
   end

   // Drive selection; input lockout beats output forcing
   always @*
   begin
      prim_d = pwm_primary_i;
      sec_d = pwm_secondary_i;
      if (in_lock)
      begin
         prim_d = 1'b0;
         sec_d = 1'b0;
      end
      else if (ov_force)
      begin
         prim_d = 1'b0;
         sec_d = 1'b1;
      end
   end

   // Gate drives, registered so glitches never reach the drivers
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         primary_gate_drive_o <= 1'b0;
         secondary_gate_drive_o <= 1'b0;
      end
      else
      begin
         primary_gate_drive_o <= prim_d;
         secondary_gate_drive_o <= sec_d;
      end
   end

   // Level interrupt from next status, so it rises with the flag
   assign irq_d = |(stat_d & mask_q);

   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= irq_d;
      end
   end
endmodule

// File: power_stage_model.sv
/* Output voltage comparator of the power stage.
 Assumes sensed output and DAC level share one scale. */
`timescale 1ns/100ps
module power_stage_model
(
   input wire [7:0] level_i,
   input wire [7:0] vout_i,
   output wire ov_comp_o
);
   // Trips while sensed output exceeds the DAC level
   assign ov_comp_o = vout_i > level_i;
endmodule

// File: ov_protect_sva.sv
/* Port checker for ov_protect_ctrl.
 Bound to every instance; one clock, async reset. */
`timescale 1ns/100ps
module ov_protect_sva
(
   input wire core_clk_i,
   input wire reset_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire pwm_primary_i,
   input wire primary_gate_drive_o,
   input wire [5:0] input_ov_threshold_code_o,
   input wire [7:0] ov_level_code_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   wire rd = wb_ack_o && !wb_we_i;
   wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
   chk_thr_read: assert property (rd && wb_adr_i[4:0] == 5'h0 |-> wb_dat_o[31:6] == 26'h0)
      else $error("threshold upper bits");
   chk_ctrl_read: assert property (rd && wb_adr_i[4:0] == 5'h4 |-> wb_dat_o[31:4] == 28'h0)
      else $error("control upper bits");
   chk_thr_write: assert property (wr && wb_adr_i[4:0] == 5'h0 |=>
      input_ov_threshold_code_o == $past(wb_dat_i[5:0])) else $error("threshold copy");
   chk_level_write: assert property (wr && wb_adr_i[4:0] == 5'h8 |=>
      ov_level_code_o == $past(wb_dat_i[7:0])) else $error("level copy");
   chk_prim_force: assert property (primary_gate_drive_o |-> $past(pwm_primary_i))
      else $error("primary drive");
   cover property (wr && wb_adr_i[4:0] == 5'h4);
   cover property (rd && wb_adr_i[4:0] == 5'h10);
   cover property ($fell(primary_gate_drive_o));
endmodule
bind ov_protect_ctrl ov_protect_sva chk (.core_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .pwm_primary_i,
   .primary_gate_drive_o, .input_ov_threshold_code_o, .ov_level_code_o);

// File: ov_protect_ctrl_tb.sv
/* Bench for ov_protect_ctrl: Wishbone tasks, random register traffic, edge sweeps.
 Assumes the power stage model drives the output comparator. */
`timescale 1ns/100ps
`include "ov_protect_regs.vh"
`define CMP(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module ov_protect_ctrl_tb;
   reg core_clk_i = 0, reset_i = 1, cyc = 0, we = 0, pwm_p = 0, pwm_s = 0, in_ov = 0;
   reg [31:0] adr = 0, wdat = 0, rd, r;
   reg [7:0] vout = 0;
   reg [3:0] sel = 4'hf;
   integer seed = 32'haee2, n_fail = 0, samples_checked = 0, i, t;
   wire [31:0] dat_o;
   wire ack, prim, sec, vdis, irq, ovc;
   wire [7:0] lvl;
   ov_protect_ctrl uut (.core_clk_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ov_comp_i(ovc), .in_ov_comp_i(in_ov), .pwm_primary_i(pwm_p), .pwm_secondary_i(pwm_s),
      .primary_gate_drive_o(prim), .secondary_gate_drive_o(sec),
      .input_ov_threshold_code_o(), .ov_level_code_o(lvl), .voltage_amp_disable_o(vdis),
      .irq_o(irq));
   power_stage_model ps (.level_i(lvl), .vout_i(vout), .ov_comp_o(ovc));
   initial forever #4 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) {pwm_p, pwm_s} <= 2'($random(seed));
   task close_out;
      begin
         $display("checked %0d failed %0d", samples_checked, n_fail);
         if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task wb(input w, input [31:0] a, input [31:0] d);
      begin
         t = 0;
         @(posedge core_clk_i);
         cyc <= 1;
         we <= w;
         adr <= a;
         wdat <= d;
         do begin @(posedge core_clk_i); t++; end while (ack !== 1'b1 && t < 20);
         rd = dat_o;
         cyc <= 0;
         if (t >= 20)
         begin
            n_fail++;
            close_out;
         end
      end
   endtask
   task rdchk(input [31:0] a, input [31:0] e);
      begin
         wb(0, a, 0);
         `CMP(rd, e)
      end
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk_i);
      reset_i <= 0;
      rdchk(`ADDR_IN_THRESH, 0);
      rdchk(`ADDR_OV_CTRL, 0);
      rdchk(`ADDR_OV_LEVEL, 0);
      for (i = 0; i < 8; i++)
      begin
         r = (i == 0) ? 32'hffffffff : $random(seed);
         wb(1, `ADDR_IN_THRESH, r);
         rdchk(`ADDR_IN_THRESH, r & 32'h3f);
         wb(1, `ADDR_OV_LEVEL, r >> 8);
         rdchk(`ADDR_OV_LEVEL, (r >> 8) & 32'hff);
      end
      sel <= 4'he;
      wb(1, `ADDR_OV_LEVEL, 0);
      sel <= 4'hf;
      wb(1, 32'h18, 32'hff);
      rdchk(32'h18, 0);
      `CMP(lvl, r[15:8])
      wb(1, `ADDR_OV_LEVEL, 32'h80);
      wb(1, `ADDR_ANA_EN, 3);
      rdchk(`ADDR_IRQ_MASK, 0);
      `CMP(vdis, 1'b1)
      for (i = 0; i < 4; i++)
      begin
         wb(1, `ADDR_OV_CTRL, 32'h8 | i);
         vout <= 8'h90;
         repeat (6) @(posedge core_clk_i);
         `CMP({prim, sec, irq}, 3'b010)
         rdchk(`ADDR_IRQ_STAT, i >> 1);
         rdchk(`ADDR_OV_CTRL, 32'hc | i);
         wb(1, `ADDR_IRQ_STAT, 3);
         vout <= 8'h70;
         repeat (6) @(posedge core_clk_i);
         rdchk(`ADDR_IRQ_STAT, i & 1);
         wb(1, `ADDR_IRQ_STAT, 3);
      end
      wb(1, `ADDR_IRQ_MASK, 1);
      vout <= 8'h90;
      repeat (6) @(posedge core_clk_i);
      `CMP(irq, 1'b1)
      wb(1, `ADDR_IRQ_STAT, 1);
      repeat (2) @(posedge core_clk_i);
      `CMP(irq, 1'b0)
      in_ov <= 1;
      repeat (6) @(posedge core_clk_i);
      `CMP({prim, sec}, 2'b00)
      close_out;
   end
endmodule
